// *** src/fcc_pkg.sv ***
// Behaviour
// - Divider write sets the loaded flag
// - Launch without loaded divider sets access error
// - New sequence overwrites non-empty buffers
// - Array write captures address and data
// - Launch clears the command-complete flag
// - Buffers-empty sets after complete clears
// - Buffered command waits; complete when all done
// - 0x05 verifies whole array, sets blank
// - 0x20 programs one word at captured address
// - 0x40 erases sector, ignores address bits 9:0
// - 0x41 mass erase needs all protect bits
// - Protected program or sector target refused
// - Mass erase with any protection refused
// - Keep high voltage on sequential programs
// - Interrupts for buffers empty and complete
// - Unknown command code sets access error
// - Access error locks out further launches
`default_nettype none

package fcc_pkg;

  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned DIVF_W = 6;

  localparam logic [7:0] CMD_ERASE_VERIFY = 8'h05;
  localparam logic [7:0] CMD_PROGRAM      = 8'h20;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h40;
  localparam logic [7:0] CMD_MASS_ERASE   = 8'h41;

  // Sector is 1024 bytes: low ten address bits drop out
  localparam int unsigned SECTOR_LSB = 10;
  localparam logic [ADDR_W-1:0] SECTOR_MASK = 16'hfc00;
  localparam logic [ADDR_W-1:0] WORD_STEP = 16'h0002;

  // Areas guarded by the protection bits
  localparam logic [ADDR_W-1:0] LOW_AREA_END    = 16'h0fff;
  localparam logic [ADDR_W-1:0] HIGH_AREA_START = 16'hf000;

  // Prescaler counts eight oscillator cycles
  localparam logic [2:0] PRESCALE_LAST = 3'h7;

  // Reset values
  localparam logic RST_BUFFERS_EMPTY   = 1'b1;
  localparam logic RST_CMD_COMPLETE    = 1'b1;
  localparam logic RST_FLAG_CLEAR      = 1'b0;

  typedef enum logic [1:0] {
    SEQ_IDLE     = 2'b00,
    SEQ_ADDR_SET = 2'b01,
    SEQ_CMD_SET  = 2'b10
  } fcc_seq_t;

  function automatic logic fcc_cmd_valid(input logic [7:0] code);
    fcc_cmd_valid = (code == CMD_ERASE_VERIFY) || (code == CMD_PROGRAM) ||
                    (code == CMD_SECTOR_ERASE) || (code == CMD_MASS_ERASE);
  endfunction

endpackage

`default_nettype wire

// *** src/fcc_timing_divider.sv ***
`default_nettype none

module fcc_timing_divider
  import fcc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              loaded,
  input  wire logic              prescale_by_eight,
  input  wire logic [DIVF_W-1:0] clock_divide_field,
  output logic                   timing_clock
);

  logic [2:0]        pre_reg;
  logic [2:0]        pre_next;
  logic [DIVF_W-1:0] cnt_reg;
  logic [DIVF_W-1:0] cnt_next;
  wire               stage_en;
  wire               cnt_wrap;

  // ----------------------------------------------------------------
  // Prescaler then field+1 divider
  // ----------------------------------------------------------------
  assign stage_en = !prescale_by_eight || (pre_reg == PRESCALE_LAST);
  assign cnt_wrap = stage_en && (cnt_reg == clock_divide_field);
  assign pre_next = (loaded && prescale_by_eight) ? pre_reg + 3'h1 : 3'h0;
  assign cnt_next = !loaded ? '0 :
                    cnt_wrap ? '0 :
                    stage_en ? cnt_reg + {{(DIVF_W-1){1'b0}}, 1'b1} : cnt_reg;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pre_reg      <= 3'h0;
      cnt_reg      <= '0;
      timing_clock <= 1'b0;
    end
    else
    begin
      pre_reg      <= pre_next;
      cnt_reg      <= cnt_next;
      timing_clock <= loaded && cnt_wrap;
    end
  end

endmodule

`default_nettype wire

// *** src/fcc_controller.sv ***
`default_nettype none

module fcc_controller
  import fcc_pkg::*;
(
  input  wire logic              CLK,
  input  wire logic              RESET,
  // Divider load
  input  wire logic              DIV_WR,
  input  wire logic              DIV_WR_PRESCALE_BY_EIGHT,
  input  wire logic [DIVF_W-1:0] DIV_WR_CLOCK_DIVIDE_FIELD,
  output logic                   DIVIDER_LOADED_FLAG,
  output logic                   TIMING_CLOCK,
  // Command write sequence
  input  wire logic              ARRAY_WR,
  input  wire logic [ADDR_W-1:0] ARRAY_WR_ADDR,
  input  wire logic [DATA_W-1:0] ARRAY_WR_DATA,
  input  wire logic              CMD_WR,
  input  wire logic [7:0]        CMD_WR_CODE,
  input  wire logic              STAT_WR,
  input  wire logic              STAT_WR_LAUNCH,
  input  wire logic              STAT_WR_CLR_ACCESS_ERROR,
  input  wire logic              STAT_WR_CLR_PROT_VIOLATION,
  // Protection
  input  wire logic              LOW_PROTECT_DISABLE,
  input  wire logic              HIGH_PROTECT_DISABLE,
  input  wire logic              PROTECT_OPEN,
  // Status and interrupts
  input  wire logic              BUFFERS_EMPTY_IRQ_EN,
  input  wire logic              COMMAND_COMPLETE_IRQ_EN,
  output logic                   BUFFERS_EMPTY_FLAG,
  output logic                   COMMAND_COMPLETE_FLAG,
  output logic                   ACCESS_ERROR_FLAG,
  output logic                   PROTECTION_VIOLATION_FLAG,
  output logic                   BLANK_FLAG,
  output logic                   BUFFERS_EMPTY_IRQ,
  output logic                   COMMAND_COMPLETE_IRQ,
  // Flash array algorithms
  output logic                   ARRAY_OP_START,
  output logic [7:0]             ARRAY_OP_CODE,
  output logic [ADDR_W-1:0]      ARRAY_OP_ADDR,
  output logic [DATA_W-1:0]      ARRAY_OP_DATA,
  output logic                   ARRAY_HV_KEEP,
  input  wire logic              ARRAY_OP_DONE,
  input  wire logic              ARRAY_BLANK
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  fcc_seq_t          seq_reg;
  fcc_seq_t          seq_next;
  logic              div_loaded_reg;
  logic              prescale_reg;
  logic [DIVF_W-1:0] divf_reg;
  logic [ADDR_W-1:0] buf_addr_reg;
  logic [DATA_W-1:0] buf_data_reg;
  logic [7:0]        buf_cmd_reg;
  logic              buf_pending_reg;
  logic              act_busy_reg;
  logic              cbe_reg;
  logic              cc_reg;
  logic              acc_reg;
  logic              protection_violation_flag_reg;
  logic              blank_reg;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire locked      = acc_reg || protection_violation_flag_reg;
  wire arr_ok      = ARRAY_WR && !locked && (seq_reg == SEQ_IDLE);
  wire arr_bad     = ARRAY_WR && !locked && (seq_reg != SEQ_IDLE);
  wire cmd_in_seq  = CMD_WR && !locked && (seq_reg == SEQ_ADDR_SET);
  wire cmd_ok      = cmd_in_seq && fcc_cmd_valid(CMD_WR_CODE);
  wire cmd_bad     = (CMD_WR && !locked && !cmd_in_seq) ||
                     (cmd_in_seq && !fcc_cmd_valid(CMD_WR_CODE));
  wire launch_try  = STAT_WR && STAT_WR_LAUNCH && !locked &&
                     (seq_reg == SEQ_CMD_SET);
  wire all_open    = LOW_PROTECT_DISABLE && HIGH_PROTECT_DISABLE &&
                     PROTECT_OPEN;
  wire [ADDR_W-1:0] sect_lo = buf_addr_reg & SECTOR_MASK;
  wire [ADDR_W-1:0] sect_hi = buf_addr_reg | ~SECTOR_MASK;
  wire [ADDR_W-1:0] tgt_lo  = (buf_cmd_reg == CMD_SECTOR_ERASE) ? sect_lo
                                                                : buf_addr_reg;
  wire [ADDR_W-1:0] tgt_hi  = (buf_cmd_reg == CMD_SECTOR_ERASE) ? sect_hi
                                                                : buf_addr_reg;
  wire tgt_prot    = !PROTECT_OPEN ||
                     (!LOW_PROTECT_DISABLE && tgt_lo <= LOW_AREA_END) ||
                     (!HIGH_PROTECT_DISABLE && tgt_hi >= HIGH_AREA_START);
  wire prot_bad    = ((buf_cmd_reg == CMD_PROGRAM ||
                       buf_cmd_reg == CMD_SECTOR_ERASE) && tgt_prot) ||
                     ((buf_cmd_reg == CMD_MASS_ERASE) && !all_open);
  wire launch_nodiv = launch_try && !div_loaded_reg;
  wire launch_prot  = launch_try && div_loaded_reg && prot_bad;
  wire launch_ok    = launch_try && div_loaded_reg && !prot_bad;
  wire act_done     = act_busy_reg && ARRAY_OP_DONE;
  wire move         = buf_pending_reg && !act_busy_reg;
  wire seq_prog     = (buf_cmd_reg == CMD_PROGRAM) &&
                      (ARRAY_OP_CODE == CMD_PROGRAM) &&
                      (buf_addr_reg == ARRAY_OP_ADDR + WORD_STEP);

  always_comb
  begin
    seq_next = seq_reg;
    case (seq_reg)
      SEQ_IDLE:     if (arr_ok) seq_next = SEQ_ADDR_SET;
      SEQ_ADDR_SET: if (cmd_ok) seq_next = SEQ_CMD_SET;
                    else if (cmd_bad || arr_bad) seq_next = SEQ_IDLE;
      SEQ_CMD_SET:  if (launch_try || cmd_bad || arr_bad) seq_next = SEQ_IDLE;
      default:      seq_next = SEQ_IDLE;
    endcase
    if (locked)
      seq_next = SEQ_IDLE;
  end

  // ----------------------------------------------------------------
  // Divider and timing clock
  // ----------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      div_loaded_reg <= 1'b0;
      prescale_reg   <= 1'b0;
      divf_reg       <= '0;
    end
    else if (DIV_WR)
    begin
      div_loaded_reg <= 1'b1;
      prescale_reg   <= DIV_WR_PRESCALE_BY_EIGHT;
      divf_reg       <= DIV_WR_CLOCK_DIVIDE_FIELD;
    end
  end

  // Every load restarts the divider so the new rate applies at once
  wire div_restart = RESET || DIV_WR;

  fcc_timing_divider u_div (
    .clk                (CLK),
    .reset              (div_restart),
    .loaded             (div_loaded_reg),
    .prescale_by_eight  (prescale_reg),
    .clock_divide_field (divf_reg),
    .timing_clock       (TIMING_CLOCK)
  );

  // ----------------------------------------------------------------
  // Buffer stage
  // ----------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      seq_reg         <= SEQ_IDLE;
      buf_addr_reg    <= '0;
      buf_data_reg    <= '0;
      buf_cmd_reg     <= 8'h00;
      buf_pending_reg <= 1'b0;
    end
    else
    begin
      seq_reg <= seq_next;
      if (arr_ok)
      begin
        buf_addr_reg    <= ARRAY_WR_ADDR;
        buf_data_reg    <= ARRAY_WR_DATA;
        buf_pending_reg <= 1'b0;
      end
      else if (launch_ok)
        buf_pending_reg <= 1'b1;
      else if (move)
        buf_pending_reg <= 1'b0;
      if (cmd_ok)
        buf_cmd_reg <= CMD_WR_CODE;
    end
  end

  // ----------------------------------------------------------------
  // Active stage
  // ----------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      act_busy_reg   <= 1'b0;
      ARRAY_OP_START <= 1'b0;
      ARRAY_OP_CODE  <= 8'h00;
      ARRAY_OP_ADDR  <= '0;
      ARRAY_OP_DATA  <= '0;
      ARRAY_HV_KEEP  <= 1'b0;
    end
    else
    begin
      ARRAY_OP_START <= move;
      ARRAY_HV_KEEP  <= act_busy_reg && buf_pending_reg && seq_prog;
      if (move)
      begin
        act_busy_reg  <= 1'b1;
        ARRAY_OP_CODE <= buf_cmd_reg;
        ARRAY_OP_ADDR <= (buf_cmd_reg == CMD_SECTOR_ERASE) ?
                         sect_lo : buf_addr_reg;
        ARRAY_OP_DATA <= buf_data_reg;
      end
      else if (act_done)
        act_busy_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      cbe_reg   <= RST_BUFFERS_EMPTY;
      cc_reg    <= RST_CMD_COMPLETE;
      acc_reg   <= RST_FLAG_CLEAR;
      protection_violation_flag_reg <= RST_FLAG_CLEAR;
      blank_reg <= RST_FLAG_CLEAR;
    end
    else
    begin
      if (launch_ok)
        cbe_reg <= 1'b0;
      else if (move)
        cbe_reg <= 1'b1;
      if (launch_ok)
        cc_reg <= 1'b0;
      else if (act_done && !buf_pending_reg)
        cc_reg <= 1'b1;
      if (arr_bad || cmd_bad || launch_nodiv)
        acc_reg <= 1'b1;
      else if (STAT_WR && STAT_WR_CLR_ACCESS_ERROR)
        acc_reg <= 1'b0;
      if (launch_prot)
        protection_violation_flag_reg <= 1'b1;
      else if (STAT_WR && STAT_WR_CLR_PROT_VIOLATION)
        protection_violation_flag_reg <= 1'b0;
      if (launch_ok)
        blank_reg <= 1'b0;
      else if (act_done && ARRAY_OP_CODE == CMD_ERASE_VERIFY)
        blank_reg <= ARRAY_BLANK;
    end
  end

  assign DIVIDER_LOADED_FLAG       = div_loaded_reg;
  assign BUFFERS_EMPTY_FLAG        = cbe_reg;
  assign COMMAND_COMPLETE_FLAG     = cc_reg;
  assign ACCESS_ERROR_FLAG         = acc_reg;
  assign PROTECTION_VIOLATION_FLAG = protection_violation_flag_reg;
  assign BLANK_FLAG                = blank_reg;
  assign BUFFERS_EMPTY_IRQ    = cbe_reg && BUFFERS_EMPTY_IRQ_EN;
  assign COMMAND_COMPLETE_IRQ = cc_reg && COMMAND_COMPLETE_IRQ_EN;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  sequence s_launch;
    launch_ok;
  endsequence

  sequence s_dispatch;
    !cc_reg ##1 (act_busy_reg || buf_pending_reg || cbe_reg);
  endsequence

  a_div_load_flag: assert property (DIV_WR |=> DIVIDER_LOADED_FLAG [*2])
    else $error("divider write did not set loaded flag");

  a_nodiv_error: assert property (launch_try && !div_loaded_reg |=>
    ACCESS_ERROR_FLAG && !buf_pending_reg && !ARRAY_OP_START)
    else $error("launch without divider not refused");

  a_launch_clears_cc: assert property (s_launch |=> s_dispatch)
    else $error("launch did not clear command complete");

  a_cbe_after_move: assert property (move |=> BUFFERS_EMPTY_FLAG &&
    !COMMAND_COMPLETE_FLAG)
    else $error("buffers empty not set after dispatch");

  a_wait_active: assert property (act_busy_reg && !act_done |=>
    !ARRAY_OP_START)
    else $error("buffered command started while busy");

  a_cc_all_done: assert property (act_done && !buf_pending_reg &&
    !launch_ok |=> COMMAND_COMPLETE_FLAG)
    else $error("complete flag not set when idle");

  a_bad_code: assert property (cmd_in_seq && !fcc_cmd_valid(CMD_WR_CODE)
    |=> ACCESS_ERROR_FLAG)
    else $error("invalid command did not set access error");

  a_prot_refuse: assert property (launch_prot |=>
    PROTECTION_VIOLATION_FLAG && !buf_pending_reg ##1 !ARRAY_OP_START)
    else $error("protected target launched");

  a_mass_prot: assert property (launch_try && div_loaded_reg &&
    buf_cmd_reg == CMD_MASS_ERASE && !all_open |=>
    PROTECTION_VIOLATION_FLAG)
    else $error("mass erase launched under protection");

  a_lock_launch: assert property (locked && !buf_pending_reg |=>
    !buf_pending_reg ##1 !ARRAY_OP_START)
    else $error("launch while locked");

  a_sector_align: assert property (ARRAY_OP_START &&
    ARRAY_OP_CODE == CMD_SECTOR_ERASE |-> ARRAY_OP_ADDR[SECTOR_LSB-1:0] == '0)
    else $error("sector erase address not aligned");

endmodule

`default_nettype wire

// *** verif/fcc_array_model.sv ***
`default_nettype none

module fcc_array_model
  import fcc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       op_start,
  input  wire logic [7:0] op_delay,
  input  wire logic       blank_cfg,
  output logic            op_done,
  output logic            array_blank
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] busy_reg;
  logic       tog_reg;

  // --------------------------------------------
  // Timed algorithm, done pulse after op_delay
  // --------------------------------------------
  assign op_done     = (busy_reg == 8'h01);
  // Result valid only with done, toggles otherwise
  assign array_blank = op_done ? blank_cfg : tog_reg;

  always_ff @(posedge clk)
  begin
    tog_reg <= reset ? 1'b0 : ~tog_reg;
    if (reset)
      busy_reg <= 8'h00;
    else if (op_start)
      busy_reg <= op_delay;
    else if (busy_reg != 8'h00)
      busy_reg <= busy_reg - 8'h01;
  end
endmodule

`default_nettype wire

// *** verif/test_flash_command_controller.sv ***
`default_nettype none

module test_flash_command_controller
  import fcc_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [7:0]  code;
    logic [15:0] addr, data, op_addr;
    logic [2:0]  prot;
    logic        blank, go, pv, ae;
  } fcc_row_t;

  logic              CLK, RESET, DIV_WR, DIV_WR_PRESCALE_BY_EIGHT;
  logic [DIVF_W-1:0] DIV_WR_CLOCK_DIVIDE_FIELD;
  logic              ARRAY_WR, CMD_WR, STAT_WR, STAT_WR_LAUNCH;
  logic              STAT_WR_CLR_ACCESS_ERROR, STAT_WR_CLR_PROT_VIOLATION;
  logic [ADDR_W-1:0] ARRAY_WR_ADDR, ARRAY_OP_ADDR;
  logic [DATA_W-1:0] ARRAY_WR_DATA, ARRAY_OP_DATA;
  logic [7:0]        CMD_WR_CODE, ARRAY_OP_CODE, op_delay;
  logic              LOW_PROTECT_DISABLE, HIGH_PROTECT_DISABLE, PROTECT_OPEN;
  logic              BUFFERS_EMPTY_IRQ_EN, COMMAND_COMPLETE_IRQ_EN;
  logic              DIVIDER_LOADED_FLAG, TIMING_CLOCK, BLANK_FLAG, blank_cfg;
  logic              BUFFERS_EMPTY_FLAG, COMMAND_COMPLETE_FLAG;
  logic              ACCESS_ERROR_FLAG, PROTECTION_VIOLATION_FLAG;
  logic              BUFFERS_EMPTY_IRQ, COMMAND_COMPLETE_IRQ, ARRAY_HV_KEEP;
  logic              ARRAY_OP_START, ARRAY_OP_DONE, ARRAY_BLANK, got;
  int                miscompares = 0, compares = 0, cyc = 0, n;

  fcc_controller fcc_controller_inst (
    .CLK(CLK), .RESET(RESET), .DIV_WR(DIV_WR),
    .DIV_WR_PRESCALE_BY_EIGHT(DIV_WR_PRESCALE_BY_EIGHT),
    .DIV_WR_CLOCK_DIVIDE_FIELD(DIV_WR_CLOCK_DIVIDE_FIELD),
    .DIVIDER_LOADED_FLAG(DIVIDER_LOADED_FLAG), .TIMING_CLOCK(TIMING_CLOCK),
    .ARRAY_WR(ARRAY_WR), .ARRAY_WR_ADDR(ARRAY_WR_ADDR),
    .ARRAY_WR_DATA(ARRAY_WR_DATA), .CMD_WR(CMD_WR), .CMD_WR_CODE(CMD_WR_CODE),
    .STAT_WR(STAT_WR), .STAT_WR_LAUNCH(STAT_WR_LAUNCH),
    .STAT_WR_CLR_ACCESS_ERROR(STAT_WR_CLR_ACCESS_ERROR),
    .STAT_WR_CLR_PROT_VIOLATION(STAT_WR_CLR_PROT_VIOLATION),
    .LOW_PROTECT_DISABLE(LOW_PROTECT_DISABLE),
    .HIGH_PROTECT_DISABLE(HIGH_PROTECT_DISABLE), .PROTECT_OPEN(PROTECT_OPEN),
    .BUFFERS_EMPTY_IRQ_EN(BUFFERS_EMPTY_IRQ_EN),
    .COMMAND_COMPLETE_IRQ_EN(COMMAND_COMPLETE_IRQ_EN),
    .BUFFERS_EMPTY_FLAG(BUFFERS_EMPTY_FLAG),
    .COMMAND_COMPLETE_FLAG(COMMAND_COMPLETE_FLAG),
    .ACCESS_ERROR_FLAG(ACCESS_ERROR_FLAG),
    .PROTECTION_VIOLATION_FLAG(PROTECTION_VIOLATION_FLAG),
    .BLANK_FLAG(BLANK_FLAG), .BUFFERS_EMPTY_IRQ(BUFFERS_EMPTY_IRQ),
    .COMMAND_COMPLETE_IRQ(COMMAND_COMPLETE_IRQ),
    .ARRAY_OP_START(ARRAY_OP_START), .ARRAY_OP_CODE(ARRAY_OP_CODE),
    .ARRAY_OP_ADDR(ARRAY_OP_ADDR), .ARRAY_OP_DATA(ARRAY_OP_DATA),
    .ARRAY_HV_KEEP(ARRAY_HV_KEEP), .ARRAY_OP_DONE(ARRAY_OP_DONE),
    .ARRAY_BLANK(ARRAY_BLANK)
  );

  fcc_array_model fcc_array_model_inst (
    .clk(CLK), .reset(RESET), .op_start(ARRAY_OP_START),
    .op_delay(op_delay), .blank_cfg(blank_cfg),
    .op_done(ARRAY_OP_DONE), .array_blank(ARRAY_BLANK)
  );

  // Distinct erased words only, each programmed once
  fcc_row_t rows [9] = '{
    '{8'h20, 16'h4002, 16'h1234, 16'h4002, 3'h7, 1'b0, 1'b1, 1'b0, 1'b0},
    '{8'h40, 16'h47ff, 16'hffff, 16'h4400, 3'h7, 1'b0, 1'b1, 1'b0, 1'b0},
    '{8'h05, 16'h1234, 16'h0000, 16'h0000, 3'h7, 1'b1, 1'b1, 1'b0, 1'b0},
    '{8'h05, 16'h0000, 16'h0000, 16'h0000, 3'h7, 1'b0, 1'b1, 1'b0, 1'b0},
    '{8'h41, 16'h8000, 16'h0000, 16'h0000, 3'h7, 1'b0, 1'b1, 1'b0, 1'b0},
    '{8'h20, 16'h0100, 16'h5555, 16'h0000, 3'h3, 1'b0, 1'b0, 1'b1, 1'b0},
    '{8'h40, 16'hf123, 16'h0000, 16'h0000, 3'h5, 1'b0, 1'b0, 1'b1, 1'b0},
    '{8'h41, 16'h8000, 16'h0000, 16'h0000, 3'h6, 1'b0, 1'b0, 1'b1, 1'b0},
    '{8'h33, 16'h4000, 16'h0000, 16'h0000, 3'h7, 1'b0, 1'b0, 1'b0, 1'b1}
  };

  always #5 CLK = ~CLK;

  always @(posedge CLK)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      miscompares++;
      report_and_stop();
    end
  end

  // ------------------------------------
  // Host bus cycles and comparisons
  // ------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic chk1(input logic seen, input logic exp);
    chk({15'h0, seen}, {15'h0, exp});
  endtask

  task automatic report_and_stop();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic run_seq(input logic [15:0] a, d, input logic [7:0] c);
    @(negedge CLK);
    {ARRAY_WR, ARRAY_WR_ADDR, ARRAY_WR_DATA} = {1'b1, a, d};
    @(negedge CLK);
    {ARRAY_WR, ARRAY_WR_ADDR, ARRAY_WR_DATA} = {1'b0, ~a, ~d};
    {CMD_WR, CMD_WR_CODE} = {1'b1, c};
    @(negedge CLK);
    {CMD_WR, CMD_WR_CODE} = {1'b0, ~c};
    {STAT_WR, STAT_WR_LAUNCH} = 2'b11;
    @(negedge CLK);
    {STAT_WR, STAT_WR_LAUNCH} = 2'b00;
  endtask

  task automatic clr_flags();
    @(negedge CLK);
    {STAT_WR, STAT_WR_CLR_ACCESS_ERROR, STAT_WR_CLR_PROT_VIOLATION} = 3'h7;
    @(negedge CLK);
    {STAT_WR, STAT_WR_CLR_ACCESS_ERROR, STAT_WR_CLR_PROT_VIOLATION} = 3'h0;
    chk1(ACCESS_ERROR_FLAG | PROTECTION_VIOLATION_FLAG, 1'b0);
  endtask

  task automatic wait_start(input int lim);
    got = 1'b0;
    for (int i = 0; i < lim && !got; i++)
    begin
      @(negedge CLK);
      got = (ARRAY_OP_START === 1'b1);
    end
  endtask

  task automatic wait_cc();
    for (int i = 0; i < 200 && COMMAND_COMPLETE_FLAG !== 1'b1; i++)
      @(negedge CLK);
    chk1(COMMAND_COMPLETE_FLAG, 1'b1);
  endtask

  task automatic div_load(input logic p8, input logic [5:0] f, input int per);
    @(negedge CLK);
    {DIV_WR, DIV_WR_PRESCALE_BY_EIGHT, DIV_WR_CLOCK_DIVIDE_FIELD} = {1'b1, p8, f};
    @(negedge CLK);
    DIV_WR = 1'b0;
    chk1(DIVIDER_LOADED_FLAG, 1'b1);
    for (n = 0; n < 600 && TIMING_CLOCK !== 1'b1; n++)
      @(negedge CLK);
    for (n = 1; n < 600; n++)
    begin
      @(negedge CLK);
      if (TIMING_CLOCK === 1'b1)
        break;
    end
    chk(n[15:0], per[15:0]);
  endtask

  // ------------------------------------
  // Main sequence
  // ------------------------------------
  initial
  begin
    {CLK, RESET, DIV_WR, DIV_WR_PRESCALE_BY_EIGHT, ARRAY_WR, CMD_WR} = 6'h10;
    {STAT_WR, STAT_WR_LAUNCH, STAT_WR_CLR_ACCESS_ERROR} = 3'h0;
    STAT_WR_CLR_PROT_VIOLATION = 1'b0;
    {LOW_PROTECT_DISABLE, HIGH_PROTECT_DISABLE, PROTECT_OPEN} = 3'h7;
    {BUFFERS_EMPTY_IRQ_EN, COMMAND_COMPLETE_IRQ_EN, blank_cfg} = 3'h0;
    {DIV_WR_CLOCK_DIVIDE_FIELD, CMD_WR_CODE, op_delay} = {6'h00, 8'h00, 8'h04};
    {ARRAY_WR_ADDR, ARRAY_WR_DATA} = 32'h0;
    repeat (12) @(negedge CLK);
    RESET = 1'b0;
    chk({5'h0, BUFFERS_EMPTY_FLAG, COMMAND_COMPLETE_FLAG,
         ACCESS_ERROR_FLAG, PROTECTION_VIOLATION_FLAG, BLANK_FLAG,
         DIVIDER_LOADED_FLAG, TIMING_CLOCK, ARRAY_OP_START, ARRAY_HV_KEEP,
         BUFFERS_EMPTY_IRQ, COMMAND_COMPLETE_IRQ}, 16'h0600);
    run_seq(16'h4000, 16'h0f0f, CMD_PROGRAM);
    wait_start(8);
    chk({14'h0, got, ACCESS_ERROR_FLAG}, 16'h0001);
    clr_flags();
    $display("test reset_and_unloaded done");
    div_load(1'b0, 6'h03, 4);
    div_load(1'b1, 6'h01, 16);
    // 100 MHz over 512 keeps the timing clock inside its band
    div_load(1'b1, 6'h3f, 512);
    $display("test divider done");
    foreach (rows[i])
    begin
      {LOW_PROTECT_DISABLE, HIGH_PROTECT_DISABLE, PROTECT_OPEN} = rows[i].prot;
      blank_cfg = rows[i].blank;
      run_seq(rows[i].addr, rows[i].data, rows[i].code);
      wait_start(8);
      chk1(got, rows[i].go);
      if (got)
      begin
        chk1(COMMAND_COMPLETE_FLAG, 1'b0);
        chk1(BUFFERS_EMPTY_FLAG, 1'b1);
        chk({8'h0, ARRAY_OP_CODE}, {8'h0, rows[i].code});
        if (rows[i].code inside {CMD_PROGRAM, CMD_SECTOR_ERASE})
          chk(ARRAY_OP_ADDR, rows[i].op_addr);
        if (rows[i].code == CMD_PROGRAM)
          chk(ARRAY_OP_DATA, rows[i].data);
        wait_cc();
        chk1(BLANK_FLAG, rows[i].blank);
      end
      chk1(PROTECTION_VIOLATION_FLAG, rows[i].pv);
      chk1(ACCESS_ERROR_FLAG, rows[i].ae);
      clr_flags();
    end
    $display("test command_table done");
    run_seq(16'h4000, 16'h1111, 8'h33);
    run_seq(16'h4000, 16'h1111, CMD_PROGRAM);
    wait_start(8);
    chk({14'h0, got, ACCESS_ERROR_FLAG}, 16'h0001);
    clr_flags();
    $display("test lockout done");
    op_delay = 8'h30;
    run_seq(16'h4000, 16'h0001, CMD_PROGRAM);
    run_seq(16'h4002, 16'h0002, CMD_PROGRAM);
    chk1(BUFFERS_EMPTY_FLAG, 1'b0);
    @(negedge CLK);
    chk1(ARRAY_HV_KEEP, 1'b1);
    run_seq(16'h6000, 16'h0003, CMD_SECTOR_ERASE);
    chk1(ARRAY_HV_KEEP, 1'b0);
    for (n = 0; n < 100 && ARRAY_OP_DONE !== 1'b1; n++)
    begin
      chk1(ARRAY_OP_START, 1'b0);
      @(negedge CLK);
    end
    wait_start(4);
    chk1(got, 1'b1);
    chk({8'h0, ARRAY_OP_CODE}, {8'h0, CMD_SECTOR_ERASE});
    chk(ARRAY_OP_ADDR, 16'h6000);
    chk1(COMMAND_COMPLETE_FLAG, 1'b0);
    wait_cc();
    $display("test buffered done");
    {BUFFERS_EMPTY_IRQ_EN, COMMAND_COMPLETE_IRQ_EN} = 2'b10;
    @(negedge CLK);
    chk({14'h0, BUFFERS_EMPTY_IRQ, COMMAND_COMPLETE_IRQ}, 16'h0002);
    {BUFFERS_EMPTY_IRQ_EN, COMMAND_COMPLETE_IRQ_EN} = 2'b01;
    @(negedge CLK);
    chk({14'h0, BUFFERS_EMPTY_IRQ, COMMAND_COMPLETE_IRQ}, 16'h0001);
    $display("test interrupts done");
    RESET = 1'b1;
    repeat (2) @(negedge CLK);
    RESET = 1'b0;
    chk({14'h0, DIVIDER_LOADED_FLAG, BUFFERS_EMPTY_FLAG}, 16'h0001);
    $display("test midrun_reset done");
    report_and_stop();
  end
endmodule

`default_nettype wire
